// >>> shared/sgp_pkg.sv
package sgp_pkg;

  // Port widths
  localparam int unsigned PORT_B_W = 8;
  localparam int unsigned PORT_C_W = 5;
  localparam int unsigned PORT_D_W = 7;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PORT_B_LATCH = 6'h01;
  localparam logic [5:0] IDX_PORT_C_LATCH = 6'h02;
  localparam logic [5:0] IDX_PORT_D_LATCH = 6'h03;
  localparam logic [5:0] IDX_PORT_B_DIR = 6'h05;
  localparam logic [5:0] IDX_PORT_C_DIR = 6'h06;
  localparam logic [5:0] IDX_PORT_D_DIR = 6'h07;

  // Reset values of the direction registers
  localparam logic [7:0] PORT_B_DIR_RESET = 8'h00;
  localparam logic [7:0] PORT_C_DIR_RESET = 8'h00;
  localparam logic [6:0] PORT_D_DIR_RESET = 7'h00;

  // Third port direction register layout
  localparam int unsigned BUS_CLOCK_OUT_EN_BIT = 7;
  localparam logic [7:0] PORT_C_DIR_RW_MASK = 8'h9F;
  localparam int unsigned BUS_CLOCK_PIN = 2;

  // Fourth port timer clock pin and its prescale code
  localparam int unsigned TIMER_CLOCK_PIN = 6;
  localparam logic [2:0] TIMER_EXT_CLOCK_SEL = 3'h7;

  // Converter channel numbering
  localparam logic [4:0] ADC_PORT_D_BASE = 5'h08;
  localparam logic [4:0] ADC_LAST_CHANNEL = 5'h0E;

  // Pin drive bundle, unused upper bits stay zero
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] enable;
  } sgp_pins_t;

endpackage

// >>> hdl/sgp_ports.sv
module sgp_ports (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Converter and timer selects
  input wire logic [4:0] analog_channel_select_in,
  input wire logic [2:0] timer_prescale_select_in,
  output logic timer_ext_clock_pin_out,
  // Pins
  input wire logic [7:0] port_b_pin_in,
  input wire logic [4:0] port_c_pin_in,
  input wire logic [6:0] port_d_pin_in,
  output sgp_pkg::sgp_pins_t port_b_pins_out,
  output sgp_pkg::sgp_pins_t port_c_pins_out,
  output sgp_pkg::sgp_pins_t port_d_pins_out
);

  logic [7:0] latch_b_q;
  logic [4:0] latch_c_q;
  logic [6:0] latch_d_q;
  logic [7:0] dir_b_q;
  logic [4:0] dir_c_q;
  logic bus_clock_out_enable_q;
  logic [6:0] dir_d_q;
  logic [7:0] meta_b_q;
  logic [4:0] meta_c_q;
  logic [6:0] meta_d_q;
  logic [7:0] sync_b_q;
  logic [4:0] sync_c_q;
  logic [6:0] sync_d_q;
  logic bus_clock_q;
  logic [7:0] adc_b;
  logic [6:0] adc_d;
  logic timer_sel;
  logic [6:0] taken_d;
  logic [7:0] rd_b;
  logic [4:0] rd_c;
  logic [6:0] rd_d;
  logic setup;
  logic access_done;
  logic wr_done;
  logic [5:0] idx;
  logic aligned;
  logic [31:0] rdata_d;
  logic slverr_d;
  sgp_pkg::sgp_pins_t pins_b_d;
  sgp_pkg::sgp_pins_t pins_c_d;
  sgp_pkg::sgp_pins_t pins_d_d;

  // Bus decode
  assign setup = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_out;
  assign wr_done = access_done & pwrite_in & pstrb_in[0] & ~pslverr_out;
  assign idx = paddr_in[7:2];
  assign aligned = (paddr_in[1:0] == 2'h0);

  // Pin synchronisers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_b_q <= 8'h00;
      meta_c_q <= 5'h00;
      meta_d_q <= 7'h00;
      sync_b_q <= 8'h00;
      sync_c_q <= 5'h00;
      sync_d_q <= 7'h00;
    end else begin
      meta_b_q <= port_b_pin_in;
      meta_c_q <= port_c_pin_in;
      meta_d_q <= port_d_pin_in;
      sync_b_q <= meta_b_q;
      sync_c_q <= meta_c_q;
      sync_d_q <= meta_d_q;
    end
  end

  // Converter channel ownership; codes above the last channel select no pin
  always_comb begin
    adc_b = 8'h00;
    adc_d = 7'h00;
    if (analog_channel_select_in < sgp_pkg::ADC_PORT_D_BASE) begin
      adc_b[analog_channel_select_in[2:0]] = 1'b1;
    end else if (analog_channel_select_in <= sgp_pkg::ADC_LAST_CHANNEL) begin
      adc_d[3'(analog_channel_select_in - sgp_pkg::ADC_PORT_D_BASE)] = 1'b1;
    end
  end

  assign timer_sel = (timer_prescale_select_in == sgp_pkg::TIMER_EXT_CLOCK_SEL);

  always_comb begin
    taken_d = adc_d;
    taken_d[sgp_pkg::TIMER_CLOCK_PIN] = adc_d[sgp_pkg::TIMER_CLOCK_PIN] | timer_sel;
  end

  // Read values
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dir_b_q[i]) begin
        rd_b[i] = latch_b_q[i];
      end else begin
        rd_b[i] = adc_b[i] ? 1'b0 : sync_b_q[i];
      end
    end
    for (int i = 0; i < 5; i++) begin
      rd_c[i] = dir_c_q[i] ? latch_c_q[i] : sync_c_q[i];
    end
    if (bus_clock_out_enable_q) begin
      rd_c[sgp_pkg::BUS_CLOCK_PIN] = 1'b0;
    end
    for (int i = 0; i < 7; i++) begin
      if (dir_d_q[i]) begin
        rd_d[i] = latch_d_q[i];
      end else begin
        rd_d[i] = taken_d[i] ? 1'b0 : sync_d_q[i];
      end
    end
  end

  // Register read mux and unmapped-address answer
  always_comb begin
    rdata_d = 32'h0000_0000;
    slverr_d = 1'b0;
    if (!aligned) begin
      slverr_d = 1'b1;
    end else if (idx == sgp_pkg::IDX_PORT_B_LATCH) begin
      rdata_d[7:0] = rd_b;
    end else if (idx == sgp_pkg::IDX_PORT_C_LATCH) begin
      rdata_d[4:0] = rd_c;
    end else if (idx == sgp_pkg::IDX_PORT_D_LATCH) begin
      rdata_d[6:0] = rd_d;
    end else if (idx == sgp_pkg::IDX_PORT_B_DIR) begin
      rdata_d[7:0] = dir_b_q;
    end else if (idx == sgp_pkg::IDX_PORT_C_DIR) begin
      rdata_d[4:0] = dir_c_q;
      rdata_d[sgp_pkg::BUS_CLOCK_OUT_EN_BIT] = bus_clock_out_enable_q;
    end else if (idx == sgp_pkg::IDX_PORT_D_DIR) begin
      rdata_d[6:0] = dir_d_q;
    end else begin
      slverr_d = 1'b1;
    end
  end

  // Answer is prepared in the setup cycle, so every access has no wait state
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      if (setup) begin
        pslverr_out <= slverr_d;
        prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_d;
      end else if (access_done) begin
        pslverr_out <= 1'b0;
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // Data latches hold through reset
  always_ff @(posedge ref_clk_in) begin
    if (wr_done && idx == sgp_pkg::IDX_PORT_B_LATCH) begin
      latch_b_q <= pwdata_in[7:0];
    end
    if (wr_done && idx == sgp_pkg::IDX_PORT_C_LATCH) begin
      latch_c_q <= pwdata_in[4:0];
    end
    if (wr_done && idx == sgp_pkg::IDX_PORT_D_LATCH) begin
      latch_d_q <= pwdata_in[6:0];
    end
  end

  // Direction registers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_b_q <= sgp_pkg::PORT_B_DIR_RESET;
      dir_c_q <= sgp_pkg::PORT_C_DIR_RESET[4:0];
      bus_clock_out_enable_q <= sgp_pkg::PORT_C_DIR_RESET[sgp_pkg::BUS_CLOCK_OUT_EN_BIT];
      dir_d_q <= sgp_pkg::PORT_D_DIR_RESET;
    end else if (wr_done) begin
      if (idx == sgp_pkg::IDX_PORT_B_DIR) begin
        dir_b_q <= pwdata_in[7:0];
      end
      if (idx == sgp_pkg::IDX_PORT_C_DIR) begin
        dir_c_q <= pwdata_in[4:0] & sgp_pkg::PORT_C_DIR_RW_MASK[4:0];
        bus_clock_out_enable_q <= pwdata_in[sgp_pkg::BUS_CLOCK_OUT_EN_BIT];
      end
      if (idx == sgp_pkg::IDX_PORT_D_DIR) begin
        dir_d_q <= pwdata_in[6:0];
      end
    end
  end

  // Bus clock is half the reference rate, taken from a toggling flop
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_clock_q <= 1'b0;
    end else begin
      bus_clock_q <= ~bus_clock_q;
    end
  end

  // Pin drive, registered so the pads see no decode glitches
  always_comb begin
    pins_b_d = '0;
    pins_c_d = '0;
    pins_d_d = '0;
    pins_b_d.drive = latch_b_q;
    pins_b_d.enable = dir_b_q & ~adc_b;
    pins_c_d.drive[4:0] = latch_c_q;
    pins_c_d.enable[4:0] = dir_c_q;
    if (bus_clock_out_enable_q) begin
      pins_c_d.drive[sgp_pkg::BUS_CLOCK_PIN] = ~bus_clock_q;
      pins_c_d.enable[sgp_pkg::BUS_CLOCK_PIN] = 1'b1;
    end
    pins_d_d.drive[6:0] = latch_d_q;
    pins_d_d.enable[6:0] = dir_d_q & ~taken_d;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_b_pins_out <= '0;
      port_c_pins_out <= '0;
      port_d_pins_out <= '0;
      timer_ext_clock_pin_out <= 1'b0;
    end else begin
      port_b_pins_out <= pins_b_d;
      port_c_pins_out <= pins_c_d;
      port_d_pins_out <= pins_d_d;
      timer_ext_clock_pin_out <= timer_sel & sync_d_q[sgp_pkg::TIMER_CLOCK_PIN];
    end
  end

  // Checks
  property p_b_enable;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> port_b_pins_out.enable == $past(dir_b_q & ~adc_b);
  endproperty
  a_b_enable: assert property (p_b_enable) else $error("port b enable wrong");

  // Every port B input bit not owned by the converter must show its synced pin level
  property p_b_pin_read;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (setup && !pwrite_in && aligned && idx == sgp_pkg::IDX_PORT_B_LATCH)
        |=> (prdata_out[7:0] & $past(~dir_b_q & ~adc_b))
          == ($past(sync_b_q) & $past(~dir_b_q & ~adc_b));
  endproperty
  a_b_pin_read: assert property (p_b_pin_read) else $error("pin read wrong");

  property p_b_adc_read;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (setup && !pwrite_in && aligned && idx == sgp_pkg::IDX_PORT_B_LATCH
        && (adc_b & ~dir_b_q) != 8'h00)
        |=> (prdata_out[7:0] & $past(adc_b & ~dir_b_q)) == 8'h00;
  endproperty
  a_b_adc_read: assert property (p_b_adc_read) else $error("adc pin read not 0");

  property p_latch_write;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (wr_done && idx == sgp_pkg::IDX_PORT_B_LATCH) |=> latch_b_q == $past(pwdata_in[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not written");

  property p_bus_clock_pin;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      bus_clock_out_enable_q [*2] |=> port_c_pins_out.enable[2]
        && port_c_pins_out.drive[2] != $past(port_c_pins_out.drive[2]);
  endproperty
  a_bus_clock_pin: assert property (p_bus_clock_pin) else $error("bus clock not on pin");

  property p_bus_clock_read;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (setup && !pwrite_in && aligned && idx == sgp_pkg::IDX_PORT_C_LATCH
        && bus_clock_out_enable_q) |=> !prdata_out[2];
  endproperty
  a_bus_clock_read: assert property (p_bus_clock_read) else $error("pin 2 read not 0");

  property p_enable_write;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (wr_done && idx == sgp_pkg::IDX_PORT_C_DIR)
        |=> bus_clock_out_enable_q == $past(pwdata_in[7]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("clock enable not stored");

  property p_timer_pin;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      timer_sel ##1 timer_sel |-> !port_d_pins_out.enable[6];
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("timer pin driven");

  property p_timer_read;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (setup && !pwrite_in && aligned && idx == sgp_pkg::IDX_PORT_D_LATCH
        && timer_sel) |=> prdata_out[6] == $past(dir_d_q[6] & latch_d_q[6]);
  endproperty
  a_timer_read: assert property (p_timer_read) else $error("timer pin read wrong");

  property p_d_enable;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> port_d_pins_out.enable == {1'b0, $past(dir_d_q & ~taken_d)};
  endproperty
  a_d_enable: assert property (p_d_enable) else $error("port d enable wrong");

  property p_sync_depth;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $past(reset_n_in, 2) |-> sync_d_q == $past(port_d_pin_in, 2);
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("sync depth wrong");

  property p_ready;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      setup |=> pready_out ##1 !pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("pready timing wrong");

endmodule

// >>> tb/sgp_pin_model.sv
module sgp_pin_model (
  // Design pin drive
  input sgp_pkg::sgp_pins_t b_pins_in,
  input sgp_pkg::sgp_pins_t c_pins_in,
  input sgp_pkg::sgp_pins_t d_pins_in,
  // Board levels
  input wire logic [7:0] b_ext_in,
  input wire logic [4:0] c_ext_in,
  input wire logic [6:0] d_ext_in,
  // Resolved wire levels
  output logic [7:0] b_pin_out,
  output logic [4:0] c_pin_out,
  output logic [6:0] d_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device driver wins over the weak board level
  assign b_pin_out = (b_pins_in.enable & b_pins_in.drive) | (~b_pins_in.enable & b_ext_in);
  assign c_pin_out = (c_pins_in.enable[4:0] & c_pins_in.drive[4:0])
                   | (~c_pins_in.enable[4:0] & c_ext_in);
  assign d_pin_out = (d_pins_in.enable[6:0] & d_pins_in.drive[6:0])
                   | (~d_pins_in.enable[6:0] & d_ext_in);
endmodule

// >>> tb/test_shared_gpio_ports_bcd.sv
module test_shared_gpio_ports_bcd;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_ext_clock_pin;
  logic [4:0] ch = 5'h1F;
  logic [2:0] ps = 3'h0;
  logic [7:0] eb = 8'h00;
  logic [4:0] ec = 5'h00;
  logic [6:0] ed = 7'h00;
  logic [7:0] pb;
  logic [4:0] pc;
  logic [6:0] pd;
  sgp_pkg::sgp_pins_t ob;
  sgp_pkg::sgp_pins_t oc;
  sgp_pkg::sgp_pins_t od;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  logic tog;

  sgp_ports dut (.ref_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .analog_channel_select_in(ch), .timer_prescale_select_in(ps),
    .timer_ext_clock_pin_out(timer_ext_clock_pin), .port_b_pin_in(pb), .port_c_pin_in(pc),
    .port_d_pin_in(pd), .port_b_pins_out(ob), .port_c_pins_out(oc), .port_d_pins_out(od));
  sgp_pin_model pins (.b_pins_in(ob), .c_pins_in(oc), .d_pins_in(od), .b_ext_in(eb),
    .c_ext_in(ec), .d_ext_in(ed), .b_pin_out(pb), .c_pin_out(pc), .d_pin_out(pd));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Wait is bounded; a stuck slave ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic t_reset();
    rchk(8'h14, 32'h0);
    rchk(8'h18, 32'h0);
    rchk(8'h1C, 32'h0);
    chk({ob.enable, oc.enable, od.enable}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_port_b();
    eb <= 8'h3C;
    apb(1'b1, 8'h04, 32'hA5);
    apb(1'b1, 8'h14, 32'h0F);
    repeat (4) @(posedge clk);
    rchk(8'h04, 32'h35);
    chk(ob.enable, 8'h0F);
    chk(ob.drive[3:0], 4'h5);
    ch <= 5'h05;
    repeat (4) @(posedge clk);
    rchk(8'h04, 32'h15);
    ch <= 5'h02;
    repeat (4) @(posedge clk);
    rchk(8'h04, 32'h35);
    chk(ob.enable, 8'h0B);
    ed <= 7'h7F;
    ch <= 5'h09;
    repeat (4) @(posedge clk);
    rchk(8'h0C, 32'h7D);
    ch <= 5'h1F;
    $display("port b test done");
  endtask

  task automatic t_port_c();
    ec <= 5'h0F;
    apb(1'b1, 8'h08, 32'h1F);
    apb(1'b1, 8'h18, 32'h84);
    repeat (4) @(posedge clk);
    rchk(8'h18, 32'h84);
    rchk(8'h08, 32'h0B);
    chk(oc.enable[2], 1'b1);
    @(posedge clk);
    tog = oc.drive[2];
    @(posedge clk);
    // Concatenation keeps the inversion to one bit
    chk(oc.drive[2], {31'h0, ~tog});
    apb(1'b1, 8'h18, 32'h80);
    repeat (2) @(posedge clk);
    chk(oc.enable[2], 1'b1);
    apb(1'b1, 8'h18, 32'h7F);
    rchk(8'h18, 32'h1F);
    repeat (2) @(posedge clk);
    chk(oc.enable, 8'h1F);
    $display("port c test done");
  endtask

  task automatic t_timer();
    ed <= 7'h40;
    ps <= 3'h7;
    apb(1'b1, 8'h0C, 32'h00);
    apb(1'b1, 8'h1C, 32'h40);
    repeat (4) @(posedge clk);
    chk(timer_ext_clock_pin, 1'b1);
    chk(od.enable, 8'h00);
    chk(od.drive, 8'h00);
    rchk(8'h0C, 32'h00);
    ps <= 3'h0;
    repeat (4) @(posedge clk);
    chk(od.enable, 8'h40);
    $display("timer test done");
  endtask

  task automatic t_bad_addr();
    apb(1'b1, 8'h10, 32'hFF);
    chk(err, 1'b1);
    rchk(8'h10, 32'h0);
    chk(err, 1'b1);
    $display("address test done");
  endtask

  task automatic t_keep();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h18, 32'h0);
    apb(1'b1, 8'h14, 32'hFF);
    rchk(8'h04, 32'hA5);
    apb(1'b1, 8'h18, 32'h1F);
    rchk(8'h08, 32'h1F);
    $display("latch keep test done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_port_b();
    t_port_c();
    t_timer();
    t_bad_addr();
    t_keep();
    close_out();
  end
endmodule
